// ### verilog/vsbre_randomizer_rs.v
// randomizer and reed-solomon (207,187) encoder with segment framing
// assumes the byte source runs on mclk and is locked to the symbol rate
`timescale 1ns/1ns
`include "vsbre_defines.vh"

// What this block does
// - field is 313 segments, first is sync
// - segment is 4 sync plus 828 data
// - frame two fields, 312 packet segments each
// - packet sync byte skips randomizer and coder
// - 828 three-bit symbols carry 207 bytes
// - symbol rate is 4.5 MHz*684/286
// - segment rate Sr/832, frame rate /626
// - packet source locked to symbol pacing
// - payload XORed with 16-bit field-reset PRBS
// - sixteen stage generator, eight feedback taps
// - eight fixed taps XOR bitwise MSB first
// - preload f180 in sync before segment one
// - generator steps once per payload data byte, not in parity slots
// - coder input is the randomizer output
// - RS(207,187) code, twenty parity bytes
// - parity bytes follow the 187 data bytes
// - serial input, first bit is MSB
module vsbre_randomizer_rs #(
    parameter CLK_HZ = 10000000
) (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // parallel transport bytes from the multiplexer
    input wire [7:0] tsByte,
    input wire tsValid,
    output reg tsReady,
    // serial transport bits, used while serMode is high
    input wire serMode,
    input wire serBit,
    input wire serBitValid,
    // coded bytes toward the byte interleaver
    output reg [7:0] outByte,
    output reg outValid,
    output reg outParity,
    output reg outSegFirst,
    output reg outFieldFirst,
    // framing of the symbol stream
    output reg symTick,
    output reg segSync,
    output reg fieldSyncSegment,
    output reg fieldOdd,
    // error flags, one-cycle pulses
    output reg syncErr,
    output reg underrun
);

    // ==========================================================
    // galois field helpers

    // multiply two field elements
    function [7:0] gfMul;
        input [7:0] a;
        input [7:0] b;
        reg [7:0] x;
        reg [7:0] y;
        reg [7:0] p;
        integer k;
        begin
            x = a;
            y = b;
            p = 8'h00;
            for (k = 0; k < 8; k = k + 1) begin
                if (y[0]) begin
                    p = p ^ x;
                end
                y = {1'b0, y[7:1]};
                if (x[7]) begin
                    x = {x[6:0], 1'b0} ^ `VSBRE_GF_POLY;
                end else begin
                    x = {x[6:0], 1'b0};
                end
            end
            gfMul = p;
        end
    endfunction

    // product of (x + alpha^i) for i = 0..19, low 20 coefficients
    function [8*`VSBRE_PARITY_BYTES-1:0] genPoly;
        input dummy;
        reg [8*`VSBRE_PARITY_BYTES+7:0] g;
        reg [7:0] root;
        integer i;
        integer j;
        begin
            g = {(8*`VSBRE_PARITY_BYTES+8){1'b0}};
            g[7:0] = 8'h01;
            root = 8'h01;
            for (i = 0; i < `VSBRE_PARITY_BYTES; i = i + 1) begin
                for (j = `VSBRE_PARITY_BYTES; j > 0; j = j - 1) begin
                    g[j*8 +: 8] = g[(j-1)*8 +: 8] ^ gfMul(root, g[j*8 +: 8]);
                end
                g[7:0] = gfMul(root, g[7:0]);
                root = gfMul(root, `VSBRE_GF_ALPHA);
            end
            genPoly = g[8*`VSBRE_PARITY_BYTES-1:0];
            if (dummy) begin
                genPoly = g[8*`VSBRE_PARITY_BYTES-1:0];
            end
        end
    endfunction

    localparam PW = 8 * `VSBRE_PARITY_BYTES;
    localparam [PW-1:0] GEN = genPoly(1'b0);
    localparam [39:0] NCO_STEP = `VSBRE_SR_BASE_HZ * `VSBRE_SR_MUL;
    localparam [39:0] NCO_MOD = `VSBRE_SR_DIV * CLK_HZ;
    localparam NCO_SAT = (NCO_STEP >= NCO_MOD);
    localparam [15:0] PRBS_FB = `VSBRE_PRBS_FB;

    // ==========================================================
    // state

    reg [39:0] ncoAcc;
    reg symEn;
    reg [9:0] symCnt;
    reg [8:0] segCnt;
    reg pendSync;
    reg pendData;
    reg [15:0] prbs;
    reg [PW-1:0] par;
    reg [2:0] serCnt;
    reg [7:0] serShift;
    reg [7:0] serHold;
    reg serFull;
    reg firstOfSeg;
    reg firstOfField;

    // ==========================================================
    // decode of the symbol position

    wire [39:0] ncoSum = ncoAcc + NCO_STEP;
    wire lastSym = (symCnt == `VSBRE_SEG_SYMS - 10'd1);
    wire lastSeg = (segCnt == `VSBRE_FIELD_SEGS - 9'd1);
    wire inSync = (symCnt < `VSBRE_SYNC_SYMS);
    wire isFsSeg = (segCnt == `VSBRE_FSYNC_SEG);
    wire [7:0] byteIdx = symCnt[9:2] - 8'd1;
    wire syncSlot = symEn && !isFsSeg && (symCnt == 10'd0);
    wire byteSlot = symEn && !isFsSeg && !inSync && (symCnt[1:0] == 2'b00);
    wire dataSlot = byteSlot && (byteIdx < `VSBRE_DATA_BYTES);
    wire paritySlot = byteSlot && (byteIdx >= `VSBRE_DATA_BYTES);
    wire preload = syncSlot && (segCnt == `VSBRE_FIRST_DATA_SEG);

    // byte source: serial assembler or parallel port
    wire srcValid = serMode ? serFull : tsValid;
    wire [7:0] srcByte = serMode ? serHold : tsByte;
    wire take = tsReady && srcValid;
    wire miss = tsReady && !srcValid && symEn;
    wire doData = pendData && (take || miss);
    wire [7:0] dataIn = take ? srcByte : 8'h00;

    // randomizing byte from eight fixed generator taps
    wire [7:0] randByte = {prbs[`VSBRE_RB7], prbs[`VSBRE_RB6],
        prbs[`VSBRE_RB5], prbs[`VSBRE_RB4], prbs[`VSBRE_RB3],
        prbs[`VSBRE_RB2], prbs[`VSBRE_RB1], prbs[`VSBRE_RB0]};
    wire [7:0] rsIn = dataIn ^ randByte;
    wire [15:0] prbsStep = prbs[15] ?
        ({prbs[14:0], 1'b0} ^ {PRBS_FB[14:0], 1'b1}) :
        {prbs[14:0], 1'b0};

    // ==========================================================
    // parity feedback, one multiplier per coefficient

    wire [7:0] fb = rsIn ^ par[PW-1:PW-8];
    wire [PW-1:0] parNext;
    genvar gi;
    generate
        for (gi = 0; gi < `VSBRE_PARITY_BYTES; gi = gi + 1) begin : gCoef
            if (gi == 0) begin : gLow
                assign parNext[7:0] = gfMul(fb, GEN[7:0]);
            end else begin : gHigh
                assign parNext[gi*8 +: 8] = par[(gi-1)*8 +: 8] ^
                    gfMul(fb, GEN[gi*8 +: 8]);
            end
        end
    endgenerate

    // ==========================================================
    // symbol pacing: fractional divider of mclk

    // emits one symEn per symbol; saturates when mclk is too slow
    always @(posedge mclk) begin
        if (!rst_n) begin
            ncoAcc <= 40'h0;
            symEn <= 1'b0;
        end else if (NCO_SAT) begin
            ncoAcc <= 40'h0;
            symEn <= 1'b1;
        end else if (ncoSum >= NCO_MOD) begin
            ncoAcc <= ncoSum - NCO_MOD;
            symEn <= 1'b1;
        end else begin
            ncoAcc <= ncoSum;
            symEn <= 1'b0;
        end
    end

    // ==========================================================
    // segment, field and frame counters

    // symbol within segment, segment within field, field parity
    always @(posedge mclk) begin
        if (!rst_n) begin
            symCnt <= 10'h000;
            segCnt <= 9'h000;
            fieldOdd <= 1'b0;
            symTick <= 1'b0;
            segSync <= 1'b0;
            fieldSyncSegment <= 1'b0;
        end else begin
            symTick <= symEn;
            if (symEn) begin
                segSync <= inSync;
                fieldSyncSegment <= isFsSeg;
                if (lastSym) begin
                    symCnt <= 10'h000;
                    if (lastSeg) begin
                        segCnt <= 9'h000;
                        fieldOdd <= ~fieldOdd;
                    end else begin
                        segCnt <= segCnt + 9'd1;
                    end
                end else begin
                    symCnt <= symCnt + 10'd1;
                end
            end
        end
    end

    // ==========================================================
    // serial byte assembly

    // first bit in lands in the most significant position
    always @(posedge mclk) begin
        if (!rst_n) begin
            serCnt <= 3'h0;
            serShift <= 8'h00;
            serHold <= 8'h00;
            serFull <= 1'b0;
        end else begin
            if (serBitValid) begin
                serShift <= {serShift[6:0], serBit};
                serCnt <= serCnt + 3'd1;
            end
            // a completed byte wins over the take that clears it
            if (serBitValid && serCnt == 3'h7) begin
                serHold <= {serShift[6:0], serBit};
                serFull <= 1'b1;
            end else if (take && serMode) begin
                serFull <= 1'b0;
            end
        end
    end

    // ==========================================================
    // byte requests toward the multiplexer

    // one request per sync or data byte slot, none in parity slots, standing at most one symbol period
    always @(posedge mclk) begin
        if (!rst_n) begin
            tsReady <= 1'b0;
            pendSync <= 1'b0;
            pendData <= 1'b0;
        end else if (syncSlot) begin
            tsReady <= 1'b1;
            pendSync <= 1'b1;
            pendData <= 1'b0;
        end else if (dataSlot) begin
            tsReady <= 1'b1;
            pendSync <= 1'b0;
            pendData <= 1'b1;
        end else if (take || miss) begin
            tsReady <= 1'b0;
            pendSync <= 1'b0;
            pendData <= 1'b0;
        end
    end

    // ==========================================================
    // randomizer generator

    // preload before the first data segment, step per payload byte
    always @(posedge mclk) begin
        if (!rst_n) begin
            prbs <= `VSBRE_PRBS_PRELOAD;
        end else if (preload) begin
            prbs <= `VSBRE_PRBS_PRELOAD;
        end else if (doData) begin
            prbs <= prbsStep;
        end
    end

    // ==========================================================
    // parity register and coded byte output

    // data bytes pass through, then twenty parity bytes shift out
    always @(posedge mclk) begin
        if (!rst_n) begin
            par <= {PW{1'b0}};
            outByte <= 8'h00;
            outValid <= 1'b0;
            outParity <= 1'b0;
            outSegFirst <= 1'b0;
            outFieldFirst <= 1'b0;
            firstOfSeg <= 1'b0;
            firstOfField <= 1'b0;
        end else begin
            // qualifiers stand only in the cycle of their byte
            outValid <= 1'b0;
            outParity <= 1'b0;
            outSegFirst <= 1'b0;
            outFieldFirst <= 1'b0;
            if (syncSlot) begin
                par <= {PW{1'b0}};
                firstOfSeg <= 1'b1;
                firstOfField <= (segCnt == `VSBRE_FIRST_DATA_SEG);
            end else if (doData) begin
                par <= parNext;
                outByte <= rsIn;
                outValid <= 1'b1;
                outParity <= 1'b0;
                outSegFirst <= firstOfSeg;
                outFieldFirst <= firstOfField;
                firstOfSeg <= 1'b0;
                firstOfField <= 1'b0;
            end else if (paritySlot) begin
                par <= {par[PW-9:0], 8'h00};
                outByte <= par[PW-1:PW-8];
                outValid <= 1'b1;
                outParity <= 1'b1;
                outSegFirst <= 1'b0;
                outFieldFirst <= 1'b0;
            end
        end
    end

    // ==========================================================
    // error flags

    // sync byte is checked then dropped; data byte misses become fill bytes
    always @(posedge mclk) begin
        if (!rst_n) begin
            syncErr <= 1'b0;
            underrun <= 1'b0;
        end else begin
            syncErr <= take && pendSync &&
                (srcByte != `VSBRE_TS_SYNC);
            underrun <= miss;
        end
    end

endmodule

// ### verilog/vsbre_defines.vh
// constants for the randomizer and reed-solomon front end
// assumes inclusion by bare name from the design file
`ifndef VSBRE_DEFINES_VH
`define VSBRE_DEFINES_VH

// ==========================================================
// symbol rate: base clock times multiplier over divider
`define VSBRE_SR_BASE_HZ 40'd4500000
`define VSBRE_SR_MUL 40'd684
`define VSBRE_SR_DIV 40'd286

// ==========================================================
// segment and field framing
`define VSBRE_SEG_SYMS 10'd832
`define VSBRE_SYNC_SYMS 10'd4
`define VSBRE_FIELD_SEGS 9'd313
`define VSBRE_FSYNC_SEG 9'd0
`define VSBRE_FIRST_DATA_SEG 9'd1

// ==========================================================
// byte block layout inside a data segment
`define VSBRE_BLOCK_BYTES 8'd207
`define VSBRE_DATA_BYTES 8'd187
`define VSBRE_PARITY_BYTES 20
`define VSBRE_TS_SYNC 8'h47

// ==========================================================
// randomizer: preload, feedback mask and tap positions
`define VSBRE_PRBS_PRELOAD 16'hf180
`define VSBRE_PRBS_FB 16'h1c65
`define VSBRE_RB0 0
`define VSBRE_RB1 2
`define VSBRE_RB2 3
`define VSBRE_RB3 6
`define VSBRE_RB4 10
`define VSBRE_RB5 11
`define VSBRE_RB6 12
`define VSBRE_RB7 13

// ==========================================================
// galois field: low byte of x^8+x^4+x^3+x^2+1, and alpha
`define VSBRE_GF_POLY 8'h1d
`define VSBRE_GF_ALPHA 8'h02

`endif

// ### test/vsbre_randomizer_rs_monitor.sv
// port checker for the randomizer and parity coder
// assumes the symbol pulse fires on every mclk cycle
`timescale 1ns/1ns
// ==============================
// framing and block checks
module vsbre_randomizer_rs_monitor (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // request side
    input wire tsReady,
    // coded byte side
    input wire outValid,
    input wire outParity,
    input wire outSegFirst,
    input wire outFieldFirst,
    // framing and flags
    input wire symTick,
    input wire segSync,
    input wire fieldSyncSegment,
    input wire syncErr,
    input wire underrun
);
    reg [9:0] tickCnt;
    reg [7:0] byteCnt;
    reg [4:0] parCnt;
    reg segPrev;
    reg segArmed;
    reg blkArmed;
    default clocking mon_cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // symbols per segment, bytes and parity per block
    always @(posedge mclk) begin
        if (!rst_n) begin
            tickCnt <= 10'h0;
            byteCnt <= 8'h0;
            parCnt <= 5'h0;
            segPrev <= 1'b0;
            segArmed <= 1'b0;
            blkArmed <= 1'b0;
        end else begin
            segPrev <= segSync;
            if (segSync && !segPrev) begin
                tickCnt <= {9'h0, symTick};
                segArmed <= 1'b1;
            end else
                tickCnt <= tickCnt + {9'h0, symTick};
            if (outValid) begin
                byteCnt <= outSegFirst ? 8'h1 : byteCnt + 8'h1;
                parCnt <= outSegFirst ? 5'h0 : parCnt + {4'h0, outParity};
                blkArmed <= 1'b1;
            end
        end
    end
    property p_segPeriod;
        segSync && !segPrev && segArmed |-> tickCnt == 10'h340;
    endproperty
    a_segPeriod: assert property (p_segPeriod)
        else $error("segment length wrong");
    property p_syncLen;
        $rose(segSync) |-> segSync [*4] ##1 !segSync;
    endproperty
    a_syncLen: assert property (p_syncLen)
        else $error("segment sync not four symbols");
    property p_byteSpacing;
        outValid |=> !outValid [*2] ##1
            (!outValid || (outParity && byteCnt == 8'hbb));
    endproperty
    a_byteSpacing: assert property (p_byteSpacing)
        else $error("coded bytes closer than four symbols");
    property p_reqSpacing;
        tsReady |=> !tsReady [*3];
    endproperty
    a_reqSpacing: assert property (p_reqSpacing)
        else $error("requests closer than four symbols");
    property p_blockLen;
        outValid && outSegFirst && blkArmed |->
            byteCnt == 8'hcf && parCnt == 5'h14;
    endproperty
    a_blockLen: assert property (p_blockLen)
        else $error("block not 207 bytes with 20 parity");
    property p_parityTail;
        outValid && !outSegFirst |-> outParity == (byteCnt >= 8'hbb);
    endproperty
    a_parityTail: assert property (p_parityTail)
        else $error("parity not at block end");
    property p_fromRequest;
        outValid && !outParity |-> $past(tsReady) || $past(tsReady, 2);
    endproperty
    a_fromRequest: assert property (p_fromRequest)
        else $error("data byte without request");
    property p_fieldQuiet;
        fieldSyncSegment |-> !tsReady;
    endproperty
    a_fieldQuiet: assert property (p_fieldQuiet)
        else $error("request during field sync segment");
    property p_qualifiers;
        outParity || outSegFirst || outFieldFirst |-> outValid;
    endproperty
    a_qualifiers: assert property (p_qualifiers)
        else $error("qualifier without coded byte");
    property p_errCause;
        syncErr || underrun |-> $past(tsReady) || $past(tsReady, 2);
    endproperty
    a_errCause: assert property (p_errCause)
        else $error("error pulse without request");
endmodule
bind vsbre_randomizer_rs vsbre_randomizer_rs_monitor u_mon (
    .mclk, .rst_n, .tsReady, .outValid, .outParity, .outSegFirst,
    .outFieldFirst, .symTick, .segSync, .fieldSyncSegment, .syncErr,
    .underrun
);

// ### test/vsbre_ts_source.sv
// transport packet source in place of the multiplexer
// assumes single-cycle requests taken at the rising edge
`timescale 1ns/1ns
// ==============================
// packet source
module vsbre_ts_source (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // commanded faults
    input wire [7:0] badPkt,
    input wire [7:0] skipPkt,
    input wire [7:0] skipIdx,
    // request handshake
    input wire tsReady,
    output reg tsValid,
    output reg [7:0] tsByte
);
    integer idx;
    integer pkt;
    initial begin
        tsValid = 1'b0;
        tsByte = 8'h00;
    end
    // one byte per request, sync byte leads each packet
    always @(posedge mclk) begin
        if (!rst_n) begin
            idx = 0;
            pkt = 0;
        end else if (tsReady) begin
            idx = idx + 1;
            if (idx == 188) begin
                idx = 0;
                pkt = pkt + 1;
            end
        end
        #2;
        tsValid = !(pkt == skipPkt && idx == skipIdx);
        if (!tsValid)
            tsByte = ~tsByte;
        else if (idx == 0)
            tsByte = (pkt == badPkt) ? 8'h48 : 8'h47;
        else
            tsByte = 8'(pkt * 37 + idx * 5);
    end
endmodule

// ### test/vsbre_randomizer_rs_tb_top.sv
// self-checking bench for the randomizer and parity coder
// assumes default mclk rate, one symbol per mclk cycle
`timescale 1ns/1ns
`include "vsbre_defines.vh"
// ==============================
// bench top
module vsbre_randomizer_rs_tb_top;
    reg mclk, rst_n, serMode, serBit, serBitValid;
    wire tsReady, tsValid, outValid, outParity, outSegFirst, outFieldFirst;
    wire symTick, segSync, fieldSyncSegment, fieldOdd, syncErr, underrun;
    wire [7:0] tsByte, outByte;
    integer bad_count, samples_checked, syncErrs, underruns;
    reg [10:0] q [$];
    reg [7:0] gen [0:19];
    reg [15:0] lfsr;
    vsbre_randomizer_rs dut (.mclk, .rst_n, .tsByte, .tsValid, .tsReady,
        .serMode, .serBit, .serBitValid, .outByte, .outValid, .outParity,
        .outSegFirst, .outFieldFirst, .symTick, .segSync,
        .fieldSyncSegment, .fieldOdd, .syncErr, .underrun);
    vsbre_ts_source src (.mclk, .rst_n, .badPkt(8'h01), .skipPkt(8'h02),
        .skipIdx(8'h64), .tsReady, .tsValid, .tsByte);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // record coded bytes and error pulses
    always @(posedge mclk) begin
        if (outValid)
            q.push_back({outFieldFirst, outSegFirst, outParity, outByte});
        syncErrs = syncErrs + syncErr;
        underruns = underruns + underrun;
    end
    function [7:0] gmul(input [7:0] a, input [7:0] b);
        integer i;
        begin
            gmul = 8'h00;
            for (i = 0; i < 8; i = i + 1) begin
                if (b[i])
                    gmul = gmul ^ a;
                a = {a[6:0], 1'b0} ^ (a[7] ? `VSBRE_GF_POLY : 8'h00);
            end
        end
    endfunction
    task close_out;
        begin
            $display("checks %0d mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task cmp8(input [7:0] got, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // generator coefficients from roots alpha^0..alpha^19
    task build_gen;
        integer i, j;
        reg [7:0] root;
        begin
            for (j = 1; j < 20; j = j + 1)
                gen[j] = 8'h00;
            gen[0] = 8'h01;
            root = 8'h01;
            for (i = 0; i < 20; i = i + 1) begin
                for (j = 19; j > 0; j = j - 1)
                    gen[j] = gen[j - 1] ^ gmul(gen[j], root);
                gen[0] = gmul(gen[0], root);
                root = gmul(root, 8'h02);
            end
        end
    endtask
    // field sync segment, then serial sync byte msb first
    task t_frame;
        integer n;
        reg [7:0] sb;
        begin
            sb = `VSBRE_TS_SYNC;
            n = 0;
            while (!tsReady && n < 900) begin
                @(posedge mclk);
                #2;
                n = n + 1;
                serBitValid = (n >= 820 && n < 828);
                serMode = serMode | serBitValid;
                if (serBitValid)
                    serBit = sb[827 - n];
                if (n == 400)
                    cmp8({7'h0, fieldSyncSegment}, 8'h01);
                if (n == 400)
                    cmp8({7'h0, fieldOdd}, 8'h00);
            end
            cmp8({7'h0, n >= 832 && n <= 834}, 8'h01);
            if (n >= 900)
                close_out;
            @(posedge mclk);
            #2;
            serMode = 1'b0;
            $display("test frame done");
        end
    endtask
    // one 207-byte block: randomized payload then parity
    task check_seg(input integer pkt, input integer skip,
                   input integer errs, input integer unders);
        reg [10:0] e;
        reg [7:0] par [0:19];
        reg [7:0] d, fb;
        integer i, j, n;
        begin
            n = 0;
            while (q.size() < 207 && n < 2000) begin
                @(posedge mclk);
                n = n + 1;
            end
            if (n >= 2000) begin
                bad_count = bad_count + 1;
                close_out;
            end
            for (j = 0; j < 20; j = j + 1)
                par[j] = 8'h00;
            for (i = 1; i < 208; i = i + 1) begin
                e = q.pop_front();
                d = par[19];
                if (i < 188) begin
                    d = (i == skip) ? 8'h00 : 8'(pkt * 37 + i * 5);
                    d = d ^ {lfsr[`VSBRE_RB7], lfsr[`VSBRE_RB6],
                        lfsr[`VSBRE_RB5], lfsr[`VSBRE_RB4], lfsr[`VSBRE_RB3],
                        lfsr[`VSBRE_RB2], lfsr[`VSBRE_RB1], lfsr[`VSBRE_RB0]};
                    lfsr = {lfsr[14:0], 1'b0} ^ (lfsr[15] ? 16'h38cb : 16'h0);
                    fb = d ^ par[19];
                    cmp8(e[7:0], d);
                end else begin
                    fb = 8'h00;
                    cmp8(e[7:0], d);
                end
                for (j = 19; j > 0; j = j - 1)
                    par[j] = par[j - 1] ^ gmul(fb, gen[j]);
                par[0] = gmul(fb, gen[0]);
                cmp8({5'h0, e[10:8]}, {5'h0, pkt == 0 && i == 1, i == 1,
                    i > 187});
            end
            cmp8(syncErrs[7:0], errs[7:0]);
            cmp8(underruns[7:0], unders[7:0]);
            $display("test block %0d done", pkt);
        end
    endtask
    initial begin
        rst_n = 1'b0;
        serMode = 1'b0;
        serBit = 1'b0;
        serBitValid = 1'b0;
        bad_count = 0;
        samples_checked = 0;
        syncErrs = 0;
        underruns = 0;
        lfsr = `VSBRE_PRBS_PRELOAD;
        build_gen;
        repeat (8) @(posedge mclk);
        #2;
        rst_n = 1'b1;
        t_frame;
        check_seg(0, 0, 0, 0);
        check_seg(1, 0, 1, 0);
        check_seg(2, 100, 1, 1);
        close_out;
    end
endmodule
